// file: damper_ctrl_config_regs.sv
// Configuration register bank of the damper control unit
//
// Functional notes
// - Test time reads hour low, minute high
// - Code 0 alarm, code 1 interlock all
// - Code 2 left pair, 3 right pair
// - Codes 4 to 7 interlock single damper
// - Code 8 starts test, 9 resets alarms
// - Code 10 test plus alarm reset
// - Ventilation seconds, read write, reset 1800
// - Maintenance seconds readable and writable
// - Clock registers year to seconds, 65 on
// - Master port line settings are read only
// - Slave baud takes listed rates only
// - Parity 0 none, 1 odd, 2 even
// - Stop bits one; slave stop writable
// - Month runs 1 to 12
`timescale 1ns/1ps
module damper_ctrl_config_regs #(
    parameter int unsigned TICK_CYCLES = damper_cfg_pkg::TICK_CYCLES,
    parameter logic [15:0] MASTER_BAUD = damper_cfg_pkg::BAUD_19200,
    parameter logic [15:0] MASTER_PARITY = damper_cfg_pkg::PARITY_NONE,
    parameter int unsigned INPUTS = 3
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [15:0] regAddr,
    input wire logic regRead,
    input wire logic regWrite,
    input wire logic [15:0] regWrData,
    output logic [15:0] regRdData,
    output logic regDone,
    output logic regError,
    output logic [INPUTS-1:0] extAlarmEn,
    output logic [4*INPUTS-1:0] interlockMask,
    output logic [INPUTS-1:0] testTriggerEn,
    output logic [INPUTS-1:0] alarmResetEn,
    output logic [15:0] forcedVentSeconds,
    output logic [15:0] slaveBaud,
    output logic [15:0] slaveParity,
    output logic [15:0] slaveStop,
    output logic maintenanceActive
);
    logic [15:0] testTime_r;
    logic [15:0] year_r;
    logic [15:0] month_r;
    logic [15:0] day_r;
    logic [15:0] hour_r;
    logic [15:0] minute_r;
    logic [15:0] second_r;
    logic [15:0] inFunc_r [INPUTS];
    logic [15:0] vent_r;
    logic [15:0] maint_r;
    logic [15:0] sBaud_r;
    logic [15:0] sParity_r;
    logic [15:0] sStop_r;
    logic [31:0] tickCnt_r;
    logic tick;
    logic [7:0] splitHour;
    logic [7:0] splitMinute;
    logic splitOk;
    logic mapped;
    logic [15:0] rdValue;
    logic wr;

    assign wr = regWrite && !regRead;

    minutes_splitter splitter (
        .minutes(regWrData),
        .hour(splitHour),
        .minute(splitMinute),
        .inRange(splitOk)
    );

    // One second tick
    always_ff @(posedge clock) begin
        if (rst || tickCnt_r == 32'(TICK_CYCLES - 1)) begin
            tickCnt_r <= 32'h00000000;
        end else begin
            tickCnt_r <= tickCnt_r + 32'h00000001;
        end
    end
    assign tick = tickCnt_r == 32'(TICK_CYCLES - 1);

    // Test time
    always_ff @(posedge clock) begin
        if (rst) begin
            testTime_r <= damper_cfg_pkg::RESET_TEST_TIME;
        end else if (wr && regAddr == damper_cfg_pkg::ADDR_TEST_TIME && splitOk) begin
            testTime_r <= {splitMinute, splitHour};
        end
    end

    // Real time clock fields
    always_ff @(posedge clock) begin
        if (rst) begin
            year_r <= damper_cfg_pkg::RESET_YEAR;
            month_r <= damper_cfg_pkg::RESET_MONTH;
            day_r <= damper_cfg_pkg::RESET_DAY;
            hour_r <= damper_cfg_pkg::RESET_TIME_FIELD;
            minute_r <= damper_cfg_pkg::RESET_TIME_FIELD;
            second_r <= damper_cfg_pkg::RESET_TIME_FIELD;
        end else if (wr) begin
            unique case (regAddr)
                damper_cfg_pkg::ADDR_YEAR: begin
                    year_r <= regWrData;
                end
                damper_cfg_pkg::ADDR_MONTH: begin
                    if (regWrData != 16'h0000 && regWrData <= damper_cfg_pkg::MONTH_MAX) begin
                        month_r <= regWrData;
                    end
                end
                damper_cfg_pkg::ADDR_DAY: begin
                    if (regWrData != 16'h0000 && regWrData <= damper_cfg_pkg::DAY_MAX) begin
                        day_r <= regWrData;
                    end
                end
                damper_cfg_pkg::ADDR_HOUR: begin
                    if (regWrData <= damper_cfg_pkg::HOUR_MAX) begin
                        hour_r <= regWrData;
                    end
                end
                damper_cfg_pkg::ADDR_MINUTE: begin
                    if (regWrData <= damper_cfg_pkg::MINSEC_MAX) begin
                        minute_r <= regWrData;
                    end
                end
                damper_cfg_pkg::ADDR_SECOND: begin
                    if (regWrData <= damper_cfg_pkg::MINSEC_MAX) begin
                        second_r <= regWrData;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Input function registers and their decoded enables
    genvar gi;
    generate
        for (gi = 0; gi < INPUTS; gi++) begin : g_input
            always_ff @(posedge clock) begin
                if (rst) begin
                    inFunc_r[gi] <= damper_cfg_pkg::RESET_FUNC;
                end else if (wr && regAddr == 16'(damper_cfg_pkg::ADDR_IN_FUNC0 + 16'(gi))
                             && regWrData <= damper_cfg_pkg::FUNC_TEST_RESET) begin
                    inFunc_r[gi] <= regWrData;
                end
            end

            always_ff @(posedge clock) begin
                if (rst) begin
                    extAlarmEn[gi] <= 1'b0;
                    interlockMask[4*gi +: 4] <= 4'h0;
                    testTriggerEn[gi] <= 1'b0;
                    alarmResetEn[gi] <= 1'b0;
                end else begin
                    extAlarmEn[gi] <= inFunc_r[gi] == damper_cfg_pkg::FUNC_EXT_ALARM;
                    if (inFunc_r[gi] == damper_cfg_pkg::FUNC_INTERLOCK_ALL) begin
                        interlockMask[4*gi +: 4] <= 4'hf;
                    end else if (inFunc_r[gi] == damper_cfg_pkg::FUNC_INTERLOCK_LEFT) begin
                        interlockMask[4*gi +: 4] <= 4'h3;
                    end else if (inFunc_r[gi] == damper_cfg_pkg::FUNC_INTERLOCK_RIGHT) begin
                        interlockMask[4*gi +: 4] <= 4'hc;
                    end else if (inFunc_r[gi] >= damper_cfg_pkg::FUNC_INTERLOCK_D1
                                 && inFunc_r[gi] <= damper_cfg_pkg::FUNC_INTERLOCK_D4) begin
                        interlockMask[4*gi +: 4] <= 4'h1 << 2'(inFunc_r[gi] - damper_cfg_pkg::FUNC_INTERLOCK_D1);
                    end else begin
                        interlockMask[4*gi +: 4] <= 4'h0;
                    end
                    testTriggerEn[gi] <= inFunc_r[gi] == damper_cfg_pkg::FUNC_TEST
                                         || inFunc_r[gi] == damper_cfg_pkg::FUNC_TEST_RESET;
                    alarmResetEn[gi] <= inFunc_r[gi] == damper_cfg_pkg::FUNC_ALARM_RESET
                                        || inFunc_r[gi] == damper_cfg_pkg::FUNC_TEST_RESET;
                end
            end
        end
    endgenerate

    // Forced ventilation duration
    always_ff @(posedge clock) begin
        if (rst) begin
            vent_r <= damper_cfg_pkg::RESET_VENT;
        end else if (wr && regAddr == damper_cfg_pkg::ADDR_VENT) begin
            vent_r <= regWrData;
        end
    end

    // Maintenance countdown, a write wins over the tick
    always_ff @(posedge clock) begin
        if (rst) begin
            maint_r <= damper_cfg_pkg::RESET_MAINT;
        end else if (wr && regAddr == damper_cfg_pkg::ADDR_MAINT) begin
            maint_r <= regWrData;
        end else if (tick && maint_r != 16'h0000) begin
            maint_r <= maint_r - 16'h0001;
        end
    end

    // Slave port line settings
    always_ff @(posedge clock) begin
        if (rst) begin
            sBaud_r <= damper_cfg_pkg::RESET_S_BAUD;
            sParity_r <= damper_cfg_pkg::RESET_PARITY;
            sStop_r <= damper_cfg_pkg::RESET_STOP;
        end else if (wr) begin
            if (regAddr == damper_cfg_pkg::ADDR_S_BAUD
                && (regWrData == damper_cfg_pkg::BAUD_9600 || regWrData == damper_cfg_pkg::BAUD_19200
                    || regWrData == damper_cfg_pkg::BAUD_33800
                    || regWrData == damper_cfg_pkg::BAUD_57600)) begin
                sBaud_r <= regWrData;
            end
            if (regAddr == damper_cfg_pkg::ADDR_S_PARITY && regWrData <= damper_cfg_pkg::PARITY_EVEN) begin
                sParity_r <= regWrData;
            end
            if (regAddr == damper_cfg_pkg::ADDR_S_STOP && regWrData == damper_cfg_pkg::STOP_ONE) begin
                sStop_r <= regWrData;
            end
        end
    end

    // Read multiplexer and address decode
    always_comb begin
        mapped = 1'b1;
        rdValue = 16'h0000;
        unique case (regAddr)
            damper_cfg_pkg::ADDR_TEST_TIME: rdValue = testTime_r;
            damper_cfg_pkg::ADDR_YEAR: rdValue = year_r;
            damper_cfg_pkg::ADDR_MONTH: rdValue = month_r;
            damper_cfg_pkg::ADDR_DAY: rdValue = day_r;
            damper_cfg_pkg::ADDR_HOUR: rdValue = hour_r;
            damper_cfg_pkg::ADDR_MINUTE: rdValue = minute_r;
            damper_cfg_pkg::ADDR_SECOND: rdValue = second_r;
            damper_cfg_pkg::ADDR_RSVD_A, damper_cfg_pkg::ADDR_RSVD_B: rdValue = 16'h0000;
            damper_cfg_pkg::ADDR_VENT: rdValue = vent_r;
            damper_cfg_pkg::ADDR_MAINT: rdValue = maint_r;
            damper_cfg_pkg::ADDR_M_BAUD: rdValue = MASTER_BAUD;
            damper_cfg_pkg::ADDR_M_PARITY: rdValue = MASTER_PARITY;
            damper_cfg_pkg::ADDR_M_STOP: rdValue = damper_cfg_pkg::STOP_ONE;
            damper_cfg_pkg::ADDR_S_BAUD: rdValue = sBaud_r;
            damper_cfg_pkg::ADDR_S_PARITY: rdValue = sParity_r;
            damper_cfg_pkg::ADDR_S_STOP: rdValue = sStop_r;
            default: begin
                if (regAddr >= damper_cfg_pkg::ADDR_IN_FUNC0
                    && regAddr < 16'(damper_cfg_pkg::ADDR_IN_FUNC0 + 16'(INPUTS))) begin
                    rdValue = inFunc_r[2'(regAddr - damper_cfg_pkg::ADDR_IN_FUNC0)];
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    // Access answer, one cycle after the request
    always_ff @(posedge clock) begin
        if (rst) begin
            regRdData <= 16'h0000;
            regDone <= 1'b0;
            regError <= 1'b0;
        end else begin
            regDone <= regRead || regWrite;
            regError <= (regRead || regWrite) && !mapped;
            if (regRead && mapped) begin
                regRdData <= rdValue;
            end else if (regRead) begin
                regRdData <= 16'h0000;
            end
        end
    end

    // Settings seen by the rest of the unit
    always_ff @(posedge clock) begin
        if (rst) begin
            forcedVentSeconds <= damper_cfg_pkg::RESET_VENT;
            slaveBaud <= damper_cfg_pkg::RESET_S_BAUD;
            slaveParity <= damper_cfg_pkg::RESET_PARITY;
            slaveStop <= damper_cfg_pkg::RESET_STOP;
            maintenanceActive <= 1'b0;
        end else begin
            forcedVentSeconds <= vent_r;
            slaveBaud <= sBaud_r;
            slaveParity <= sParity_r;
            slaveStop <= sStop_r;
            maintenanceActive <= maint_r != 16'h0000;
        end
    end
endmodule : damper_ctrl_config_regs

// file: damper_cfg_pkg.sv
// Constants shared by the damper configuration register bank
package damper_cfg_pkg;
    localparam int unsigned CLOCK_HZ = 100_000_000;
    localparam int unsigned TICK_SECONDS = 1;
    localparam int unsigned TICK_CYCLES = CLOCK_HZ * TICK_SECONDS;

    localparam logic [15:0] ADDR_TEST_TIME = 16'h0040;
    localparam logic [15:0] ADDR_YEAR = 16'h0041;
    localparam logic [15:0] ADDR_MONTH = 16'h0042;
    localparam logic [15:0] ADDR_DAY = 16'h0043;
    localparam logic [15:0] ADDR_HOUR = 16'h0044;
    localparam logic [15:0] ADDR_MINUTE = 16'h0045;
    localparam logic [15:0] ADDR_SECOND = 16'h0046;
    localparam logic [15:0] ADDR_IN_FUNC0 = 16'h0047;
    localparam logic [15:0] ADDR_RSVD_A = 16'h004a;
    localparam logic [15:0] ADDR_RSVD_B = 16'h004b;
    localparam logic [15:0] ADDR_VENT = 16'h004c;
    localparam logic [15:0] ADDR_MAINT = 16'h004d;
    localparam logic [15:0] ADDR_M_BAUD = 16'h0051;
    localparam logic [15:0] ADDR_M_PARITY = 16'h0052;
    localparam logic [15:0] ADDR_M_STOP = 16'h0053;
    localparam logic [15:0] ADDR_S_BAUD = 16'h0054;
    localparam logic [15:0] ADDR_S_PARITY = 16'h0055;
    localparam logic [15:0] ADDR_S_STOP = 16'h0056;

    localparam int unsigned HOUR_LSB = 0;
    localparam int unsigned MINUTE_LSB = 8;
    localparam logic [15:0] MINUTES_PER_HOUR = 16'h003c;
    localparam logic [15:0] MINUTES_PER_DAY = 16'h05a0;

    localparam logic [15:0] BAUD_9600 = 16'h2580;
    localparam logic [15:0] BAUD_19200 = 16'h4b00;
    localparam logic [15:0] BAUD_33800 = 16'h8408;
    localparam logic [15:0] BAUD_57600 = 16'he100;
    localparam logic [15:0] PARITY_NONE = 16'h0000;
    localparam logic [15:0] PARITY_ODD = 16'h0001;
    localparam logic [15:0] PARITY_EVEN = 16'h0002;
    localparam logic [15:0] STOP_ONE = 16'h0001;

    localparam logic [15:0] FUNC_EXT_ALARM = 16'h0000;
    localparam logic [15:0] FUNC_INTERLOCK_ALL = 16'h0001;
    localparam logic [15:0] FUNC_INTERLOCK_LEFT = 16'h0002;
    localparam logic [15:0] FUNC_INTERLOCK_RIGHT = 16'h0003;
    localparam logic [15:0] FUNC_INTERLOCK_D1 = 16'h0004;
    localparam logic [15:0] FUNC_INTERLOCK_D4 = 16'h0007;
    localparam logic [15:0] FUNC_TEST = 16'h0008;
    localparam logic [15:0] FUNC_ALARM_RESET = 16'h0009;
    localparam logic [15:0] FUNC_TEST_RESET = 16'h000a;

    localparam logic [15:0] RESET_TEST_TIME = 16'h0000;
    localparam logic [15:0] RESET_YEAR = 16'h07e5;
    localparam logic [15:0] RESET_MONTH = 16'h0001;
    localparam logic [15:0] RESET_DAY = 16'h0001;
    localparam logic [15:0] RESET_TIME_FIELD = 16'h0000;
    localparam logic [15:0] RESET_FUNC = 16'h0000;
    localparam logic [15:0] RESET_VENT = 16'h0708;
    localparam logic [15:0] RESET_MAINT = 16'h0000;
    localparam logic [15:0] RESET_S_BAUD = 16'h2580;
    localparam logic [15:0] RESET_PARITY = 16'h0000;
    localparam logic [15:0] RESET_STOP = 16'h0001;

    localparam logic [15:0] MONTH_MAX = 16'h000c;
    localparam logic [15:0] DAY_MAX = 16'h001f;
    localparam logic [15:0] HOUR_MAX = 16'h0017;
    localparam logic [15:0] MINSEC_MAX = 16'h003b;
endpackage : damper_cfg_pkg

// file: minutes_splitter.sv
// Splits minutes since midnight into hour and minute
`timescale 1ns/1ps
module minutes_splitter (
    input wire logic [15:0] minutes,
    output logic [7:0] hour,
    output logic [7:0] minute,
    output logic inRange
);
    logic [15:0] quot;
    logic [15:0] prod;

    always_comb begin
        quot = minutes / damper_cfg_pkg::MINUTES_PER_HOUR;
        prod = 16'(quot * damper_cfg_pkg::MINUTES_PER_HOUR);
        hour = quot[7:0];
        minute = 8'(minutes - prod);
        inRange = minutes < damper_cfg_pkg::MINUTES_PER_DAY;
    end
endmodule : minutes_splitter

// file: damper_cfg_checker_assertions.sv
// Assertions for the damper configuration register bank
`timescale 1ns/1ps
module damper_cfg_checker #(
    parameter logic [15:0] MASTER_PARITY = damper_cfg_pkg::PARITY_NONE
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [15:0] regAddr,
    input wire logic regRead,
    input wire logic regWrite,
    input wire logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    input wire logic regError,
    input wire logic [2:0] extAlarmEn,
    input wire logic [11:0] interlockMask,
    input wire logic [15:0] forcedVentSeconds,
    input wire logic maintenanceActive
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic wr;
    assign wr = regWrite && !regRead;
    property p_rsvd;
        regRead && (regAddr == damper_cfg_pkg::ADDR_RSVD_A || regAddr == damper_cfg_pkg::ADDR_RSVD_B)
            |=> regRdData == 16'h0000 && !regError;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
    property p_mro;
        regRead && regAddr == damper_cfg_pkg::ADDR_M_PARITY |=> regRdData == MASTER_PARITY;
    endproperty
    a_mro: assert property (p_mro) else $error("master parity read wrong");
    property p_mstop;
        regRead && regAddr == damper_cfg_pkg::ADDR_M_STOP |=> regRdData == damper_cfg_pkg::STOP_ONE;
    endproperty
    a_mstop: assert property (p_mstop) else $error("master stop read wrong");
    property p_vent;
        wr && regAddr == damper_cfg_pkg::ADDR_VENT |-> ##2 forcedVentSeconds == $past(regWrData, 2);
    endproperty
    a_vent: assert property (p_vent) else $error("ventilation output wrong");
    property p_maint;
        wr && regAddr == damper_cfg_pkg::ADDR_MAINT |-> ##2 maintenanceActive == ($past(regWrData, 2) != 16'h0000);
    endproperty
    a_maint: assert property (p_maint) else $error("maintenance flag wrong");
    property p_ext;
        wr && regAddr == damper_cfg_pkg::ADDR_IN_FUNC0 && regWrData == 16'h0000 |-> ##3 extAlarmEn[0];
    endproperty
    a_ext: assert property (p_ext) else $error("alarm enable missing");
    property p_left;
        wr && regAddr == 16'h0048 && regWrData == damper_cfg_pkg::FUNC_INTERLOCK_LEFT
            |-> ##3 interlockMask[7:4] == 4'h3;
    endproperty
    a_left: assert property (p_left) else $error("left pair mask wrong");
    property p_single;
        wr && regAddr == 16'h0049 && regWrData >= 16'h0004 && regWrData <= 16'h0007
            |-> ##3 interlockMask[11:8] == (4'h1 << $past(regWrData[1:0], 3));
    endproperty
    a_single: assert property (p_single) else $error("single damper mask wrong");
    c_maint: cover property (wr && regAddr == damper_cfg_pkg::ADDR_MAINT);
    c_unmapped: cover property (regRead ##1 regError);
    c_baud: cover property (wr && regAddr == damper_cfg_pkg::ADDR_S_BAUD);
endmodule : damper_cfg_checker
bind damper_ctrl_config_regs damper_cfg_checker #(.MASTER_PARITY(MASTER_PARITY)) chk (.clock(clock), .rst(rst),
    .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite), .regWrData(regWrData), .regRdData(regRdData),
    .regError(regError), .extAlarmEn(extAlarmEn), .interlockMask(interlockMask),
    .forcedVentSeconds(forcedVentSeconds), .maintenanceActive(maintenanceActive));

// file: bms_master_model.sv
// Register bus master model of the building management side
`timescale 1ns/1ps
module bms_master_model (
    input wire logic clock,
    output logic [15:0] regAddr,
    output logic regRead,
    output logic regWrite,
    output logic [15:0] regWrData,
    input wire logic [15:0] regRdData,
    input wire logic regDone,
    input wire logic regError
);
    initial begin
        regAddr = 16'h0000;
        regRead = 1'b0;
        regWrite = 1'b0;
        regWrData = 16'h0000;
    end
    task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
                          output logic [15:0] q, output logic e, output logic dn);
        @(posedge clock);
        regAddr <= a;
        regWrData <= d;
        regRead <= !w;
        regWrite <= w;
        @(posedge clock);
        regRead <= 1'b0;
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
        @(negedge clock);
        q = regRdData;
        e = regError;
        dn = regDone;
    endtask : access
endmodule : bms_master_model

// file: damper_ctrl_config_regs_tb.sv
// Self-checking testbench for the damper configuration register bank
`timescale 1ns/1ps
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin err_total++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (x)); end end
module damper_ctrl_config_regs_tb;
    localparam int unsigned TICKS = 10;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [15:0] regAddr, regWrData, regRdData, forcedVentSeconds, slaveBaud, slaveParity, slaveStop;
    logic regRead, regWrite, regDone, regError, maintenanceActive;
    logic [2:0] extAlarmEn, testTriggerEn, alarmResetEn;
    logic [11:0] interlockMask;
    int err_total = 0;
    int cmp_count = 0;
    logic [15:0] bauds [4] = '{damper_cfg_pkg::BAUD_9600, damper_cfg_pkg::BAUD_19200, damper_cfg_pkg::BAUD_33800,
        damper_cfg_pkg::BAUD_57600};
    always #5 clock = ~clock;
    bms_master_model bus (.clock(clock), .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
        .regWrData(regWrData), .regRdData(regRdData), .regDone(regDone), .regError(regError));
    damper_ctrl_config_regs #(.TICK_CYCLES(TICKS)) dut (.clock(clock), .rst(rst), .regAddr(regAddr),
        .regRead(regRead), .regWrite(regWrite), .regWrData(regWrData), .regRdData(regRdData),
        .regDone(regDone), .regError(regError), .extAlarmEn(extAlarmEn), .interlockMask(interlockMask),
        .testTriggerEn(testTriggerEn), .alarmResetEn(alarmResetEn), .forcedVentSeconds(forcedVentSeconds),
        .slaveBaud(slaveBaud), .slaveParity(slaveParity), .slaveStop(slaveStop),
        .maintenanceActive(maintenanceActive));
    function automatic logic unm(input logic [15:0] a);
        return a < 16'h0040 || a > 16'h0056 || (a > 16'h004d && a < 16'h0051);
    endfunction : unm
    function automatic logic [15:0] rval(input logic [15:0] a);
        case (a)
            16'h0041: return damper_cfg_pkg::RESET_YEAR;
            16'h0042, 16'h0043, 16'h0053, 16'h0056: return 16'h0001;
            16'h004c: return 16'h0708;
            16'h0051: return damper_cfg_pkg::BAUD_19200;
            16'h0054: return damper_cfg_pkg::BAUD_9600;
            default: return 16'h0000;
        endcase
    endfunction : rval
    function automatic logic [6:0] fexp(input int c);
        case (c)
            0: return 7'b1000000;
            1: return 7'b0111100;
            2: return 7'b0001100;
            3: return 7'b0110000;
            8: return 7'b0000010;
            9: return 7'b0000001;
            10: return 7'b0000011;
            default: return {1'b0, 4'h1 << (c - 4), 2'b00};
        endcase
    endfunction : fexp
    function automatic logic [15:0] cmax(input logic [15:0] a);
        return a == 16'h0043 ? 16'h001f : a == 16'h0044 ? 16'h0017 : 16'h003b;
    endfunction : cmax
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
        logic [15:0] q;
        logic e, dn;
        bus.access(w, a, d, q, e, dn);
        if (w) `CHK({dn, e}, 2'b10)
        else `CHK({dn, e, q}, {1'b1, unm(a), d})
    endtask : acc
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : test_done
    initial begin
        logic [15:0] h, m, v;
        int k;
        void'($urandom(32'h3585f71e));
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        for (int a = 16'h003e; a <= 16'h0058; a++) acc(0, a[15:0], rval(a[15:0]));
        `CHK({extAlarmEn, forcedVentSeconds, slaveBaud, maintenanceActive}, {3'h7, 16'h0708, 16'h2580, 1'b0})
        repeat (6) begin
            h = 16'($urandom_range(23));
            m = 16'($urandom_range(59));
            acc(1, 16'h0040, h * 16'h003c + m);
            acc(0, 16'h0040, {m[7:0], h[7:0]});
        end
        acc(1, 16'h0040, 16'h059f);
        acc(1, 16'h0040, 16'h05a0);
        acc(0, 16'h0040, 16'h3b17);
        for (int c = 0; c <= 11; c++) begin
            if (c < 11) v = 16'(c == 0 ? 0 : c == 2 ? 1 : c == 5 ? 2 : $urandom_range(2));
            k = c < 11 ? c : 10;
            acc(1, 16'h0047 + v, c[15:0]);
            acc(0, 16'h0047 + v, k[15:0]);
            `CHK({extAlarmEn[v], interlockMask[4*v+:4], testTriggerEn[v], alarmResetEn[v]}, fexp(k))
        end
        v = 16'($urandom);
        acc(1, 16'h0041, v);
        acc(0, 16'h0041, v);
        acc(1, 16'h0042, 16'h000c);
        acc(1, 16'h0042, 16'h000d);
        acc(1, 16'h0042, 16'h0000);
        acc(0, 16'h0042, 16'h000c);
        for (int a = 16'h0043; a <= 16'h0046; a++) begin
            acc(1, a[15:0], cmax(a[15:0]));
            acc(1, a[15:0], cmax(a[15:0]) + 16'h0001);
            acc(0, a[15:0], cmax(a[15:0]));
        end
        for (int a = 16'h0051; a <= 16'h0053; a++) begin
            acc(1, a[15:0], 16'h0005);
            acc(0, a[15:0], rval(a[15:0]));
        end
        for (int i = 0; i < 4; i++) begin
            acc(1, 16'h0054, bauds[i]);
            acc(0, 16'h0054, bauds[i]);
            `CHK(slaveBaud, bauds[i])
        end
        acc(1, 16'h0054, 16'h1234);
        acc(0, 16'h0054, 16'he100);
        for (int p = 3; p >= 0; p--) acc(1, 16'h0055, p[15:0]);
        acc(0, 16'h0055, 16'h0000);
        acc(1, 16'h0056, 16'h0002);
        acc(0, 16'h0056, 16'h0001);
        `CHK({slaveParity, slaveStop}, {16'h0000, 16'h0001})
        acc(1, 16'h004a, v);
        acc(0, 16'h004a, 16'h0000);
        acc(1, 16'h004c, v);
        acc(0, 16'h004c, v);
        `CHK(forcedVentSeconds, v)
        acc(1, 16'h004d, 16'h0003);
        @(negedge clock);
        `CHK(maintenanceActive, 1'b1)
        repeat (TICKS * 5) @(posedge clock);
        acc(0, 16'h004d, 16'h0000);
        `CHK(maintenanceActive, 1'b0)
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        acc(0, 16'h004c, 16'h0708);
        `CHK({forcedVentSeconds, slaveBaud}, {16'h0708, 16'h2580})
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        test_done();
    end
endmodule : damper_ctrl_config_regs_tb
